// ===== include/arb_table_params.svh
/*
  Offsets, field positions, reset values and counts for the port arbitration
  phase table. Assumes 32-bit APB data and a 12-bit configuration offset.
*/
`ifndef ARB_TABLE_PARAMS_SVH
`define ARB_TABLE_PARAMS_SVH

// Register offsets
`define ARB_CTRL_OFF     12'h214
`define ARB_STAT_OFF     12'h218
`define ARB_TBL0_OFF     12'h220
`define ARB_TBL1_OFF     12'h224
`define ARB_TBL2_OFF     12'h228

// Field positions
`define ARB_LOAD_BIT     16
`define ARB_SEL_LSB      17
`define ARB_SEL_MSB      19
`define ARB_PEND_BIT     16
`define ARB_SLOT_W       4
`define ARB_SLOTS_WORD   8

// Table geometry
`define ARB_NUM_WORDS    3
`define ARB_NUM_PHASES   24
`define ARB_LAST_WORD    2'h2

// Reset values: phases 0..23 repeat 0x2, 0x4, 0x6 from phase zero
`define ARB_TBL0_RST     32'h42642642
`define ARB_TBL1_RST     32'h26426426
`define ARB_TBL2_RST     32'h64264264
`define ARB_SEL_RST      3'h0

// Port identifiers that name a real ingress port
`define ARB_PORT_ZERO    4'h0
`define ARB_PORT_TWO     4'h2
`define ARB_PORT_FOUR    4'h4

// Scheme select values that consult the table (one bit per select value)
`define ARB_TBL_SCHEMES  8'hfe

`endif

// ===== include/arb_table_pkg.sv
/*
  Types shared by the port arbitration phase table files.
  Assumes the constants header is included where numbers are needed.
*/
package arb_table_pkg;

  // APB request carried as one bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef logic [2:0][31:0] arb_words_type;
  typedef logic [3:0]       slot_type;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_COPY = 2'b01
  } load_state_type;

endpackage : arb_table_pkg

// ===== rtl/arb_work_mem.sv
/*
  Working copy of the arbitration table, as seen by the arbitration logic.
  Written one word per cycle by the loader; contents come out of registers.
  Assumes a synchronous active-high reset on the core clock.
*/
`timescale 1ns/1ps
`include "arb_table_params.svh"

module arb_work_mem
  import arb_table_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          we,
  input  wire logic [1:0]    waddr,
  input  wire logic [31:0]   wdata,
  output arb_words_type      words_r
);

  arb_words_type words_nxt;

  // Next contents: one word replaced per write
  always_comb begin
    words_nxt = words_r;
    if (we) begin
      words_nxt[waddr] = wdata;
    end
  end

  // Storage, reset to the default phase pattern
  always_ff @(posedge clk) begin
    if (rst) begin
      words_r <= {`ARB_TBL2_RST, `ARB_TBL1_RST, `ARB_TBL0_RST};
    end else begin
      words_r <= words_nxt;
    end
  end

endmodule : arb_work_mem

// ===== rtl/port_arbitration_phase_table.sv
/*
  Port arbitration phase table with APB register access, load and coherency
  handling, and a phase walker that grants one ingress port per period.
  Assumes phase_advance and upstream_mode are driven on clk by core logic.
*/
`timescale 1ns/1ps
`include "arb_table_params.svh"

module port_arbitration_phase_table
  import arb_table_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire apb_req_type  apb_req,
  input  wire logic         upstream_mode,
  input  wire logic         phase_advance,
  output logic [31:0]       prdata_r,
  output logic              pready_r,
  output logic              pslverr_r,
  output slot_type          grant_port_r,
  output logic              grant_valid_r,
  output logic              table_used_r
);

  arb_words_type  table_r, table_nxt, work_words;
  logic [2:0]     sel_r, sel_nxt;
  logic           pend_r, pend_nxt;
  load_state_type ld_r, ld_nxt;
  logic [1:0]     cp_idx_r, cp_idx_nxt;
  logic [4:0]     phase_r, phase_nxt;
  logic [31:0]    prdata_nxt;
  logic           pready_nxt, pslverr_nxt;
  slot_type       grant_port_nxt;
  logic           grant_valid_nxt, table_used_nxt;
  logic           setup, wr_acc, tbl_wr, ctrl_wr, load_req, table_use;
  logic           mapped, mem_we, found;
  logic [4:0]     next_phase;
  slot_type       slot_code [`ARB_NUM_PHASES];
  logic [`ARB_NUM_PHASES-1:0] slot_ok;
  logic           rst_seen_r;
  localparam logic [7:0] table_scheme_mask = `ARB_TBL_SCHEMES;

  // Working table copy read by the phase walker
  arb_work_mem u_work (
    .clk     (clk),
    .rst     (rst),
    .we      (mem_we),
    .waddr   (cp_idx_r),
    .wdata   (table_r[cp_idx_r]),
    .words_r (work_words)
  );

  // Bus decode: one wait-free access phase per transfer
  assign setup   = apb_req.psel & ~apb_req.penable;
  assign wr_acc  = apb_req.psel & apb_req.penable & pready_r & apb_req.pwrite;
  assign tbl_wr  = wr_acc & (apb_req.paddr == `ARB_TBL0_OFF ||
                             apb_req.paddr == `ARB_TBL1_OFF ||
                             apb_req.paddr == `ARB_TBL2_OFF);
  assign ctrl_wr = wr_acc & (apb_req.paddr == `ARB_CTRL_OFF);
  assign load_req  = ctrl_wr & apb_req.pwdata[`ARB_LOAD_BIT] & upstream_mode;
  assign table_use = table_scheme_mask[sel_r];
  assign mapped  = apb_req.paddr == `ARB_CTRL_OFF || apb_req.paddr == `ARB_STAT_OFF ||
                   apb_req.paddr == `ARB_TBL0_OFF || apb_req.paddr == `ARB_TBL1_OFF ||
                   apb_req.paddr == `ARB_TBL2_OFF;
  assign mem_we  = (ld_r == LD_COPY);

  // Per-slot decode of the working copy
  genvar gi;
  generate
    for (gi = 0; gi < `ARB_NUM_PHASES; gi++) begin : g_slot
      assign slot_code[gi] = work_words[gi / `ARB_SLOTS_WORD]
                             [(gi % `ARB_SLOTS_WORD) * `ARB_SLOT_W +: `ARB_SLOT_W];
      assign slot_ok[gi] = slot_code[gi] == `ARB_PORT_ZERO ||
                           slot_code[gi] == `ARB_PORT_TWO  ||
                           slot_code[gi] == `ARB_PORT_FOUR;
    end
  endgenerate

  // Search for the next valid phase after the current one, all in one cycle
  always_comb begin
    logic [5:0] idx;
    idx        = 6'h00;
    found      = 1'b0;
    next_phase = phase_r;
    for (int k = 1; k <= `ARB_NUM_PHASES; k++) begin
      idx = {1'b0, phase_r} + 6'(k);
      if (idx >= 6'(`ARB_NUM_PHASES)) begin
        idx = idx - 6'(`ARB_NUM_PHASES);
      end
      if (!found && slot_ok[idx[4:0]]) begin
        found      = 1'b1;
        next_phase = idx[4:0];
      end
    end
  end

  // Register file next state
  always_comb begin
    table_nxt   = table_r;
    sel_nxt     = sel_r;
    prdata_nxt  = prdata_r;
    pready_nxt  = setup;
    pslverr_nxt = setup & ~mapped;
    if (tbl_wr) begin
      table_nxt[apb_req.paddr[3:2]] = apb_req.pwdata;
    end
    if (ctrl_wr) begin
      sel_nxt = apb_req.pwdata[`ARB_SEL_MSB:`ARB_SEL_LSB];
    end
    if (setup) begin
      case (apb_req.paddr)
        `ARB_TBL0_OFF: prdata_nxt = table_r[0];
        `ARB_TBL1_OFF: prdata_nxt = table_r[1];
        `ARB_TBL2_OFF: prdata_nxt = table_r[2];
        `ARB_CTRL_OFF: prdata_nxt = {12'h000, sel_r, 1'b0, 16'h0000};
        `ARB_STAT_OFF: prdata_nxt = {15'h0000, pend_r, 16'h0000};
        default:       prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      table_r   <= {`ARB_TBL2_RST, `ARB_TBL1_RST, `ARB_TBL0_RST};
      sel_r     <= `ARB_SEL_RST;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      table_r   <= table_nxt;
      sel_r     <= sel_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Loader and coherency status; a write in the last copy cycle keeps pending set
  always_comb begin
    ld_nxt     = ld_r;
    cp_idx_nxt = cp_idx_r;
    pend_nxt   = pend_r;
    case (ld_r)
      LD_IDLE: begin
        if (load_req) begin
          ld_nxt     = LD_COPY;
          cp_idx_nxt = 2'h0;
        end
      end
      LD_COPY: begin
        cp_idx_nxt = cp_idx_r + 2'h1;
        if (cp_idx_r == `ARB_LAST_WORD) begin
          ld_nxt     = LD_IDLE;
          cp_idx_nxt = 2'h0;
          pend_nxt   = 1'b0;
        end
      end
      default: begin
        ld_nxt     = LD_IDLE;
        cp_idx_nxt = 2'h0;
      end
    endcase
    if (tbl_wr && upstream_mode) begin
      pend_nxt = 1'b1;
    end
    if (!upstream_mode) begin
      pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ld_r     <= LD_IDLE;
      cp_idx_r <= 2'h0;
      pend_r   <= 1'b0;
    end else begin
      ld_r     <= ld_nxt;
      cp_idx_r <= cp_idx_nxt;
      pend_r   <= pend_nxt;
    end
  end

  // Phase walker and grant outputs
  always_comb begin
    phase_nxt       = phase_r;
    grant_port_nxt  = grant_port_r;
    grant_valid_nxt = grant_valid_r & table_use;
    table_used_nxt  = table_use;
    if (phase_advance && table_use) begin
      grant_valid_nxt = found;
      if (found) begin
        phase_nxt      = next_phase;
        grant_port_nxt = slot_code[next_phase];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r       <= 5'(`ARB_NUM_PHASES - 1);
      grant_port_r  <= 4'h0;
      grant_valid_r <= 1'b0;
      table_used_r  <= 1'b0;
      rst_seen_r    <= 1'b1;
    end else begin
      phase_r       <= phase_nxt;
      grant_port_r  <= grant_port_nxt;
      grant_valid_r <= grant_valid_nxt;
      table_used_r  <= table_used_nxt;
      rst_seen_r    <= 1'b0;
    end
  end

  // Checks
  sequence seq_load_start;
    ld_r == LD_IDLE && load_req;
  endsequence

  sequence seq_copy_quiet;
    !tbl_wr [*3];
  endsequence

  decode_valid_a: assert property (@(posedge clk) disable iff (rst)
    grant_valid_r |-> grant_port_r inside {4'h0, 4'h2, 4'h4})
    else $error("grant names a port other than zero, two or four");

  reserved_never_a: assert property (@(posedge clk) disable iff (rst)
    $rose(grant_valid_r) |-> !(grant_port_r inside {4'h1, 4'h3}) && grant_port_r < 4'h5)
    else $error("reserved slot code granted");

  skip_nodelay_a: assert property (@(posedge clk) disable iff (rst)
    phase_advance && table_use && |slot_ok |=> grant_valid_r)
    else $error("valid phase not granted in the next cycle");

  slot_layout_a: assert property (@(posedge clk) disable iff (rst)
    $rose(grant_valid_r) && $past(!mem_we) |-> grant_port_r ==
      work_words[phase_r / 8][(phase_r % 8) * 4 +: 4])
    else $error("grant does not match slot nibble of phase");

  reset_pattern_a: assert property (@(posedge clk) disable iff (rst)
    rst_seen_r |-> table_r == {32'h64264264, 32'h26426426, 32'h42642642})
    else $error("table not at default pattern after reset");

  write_word_a: assert property (@(posedge clk) disable iff (rst)
    wr_acc && apb_req.paddr == 12'h224 |=> table_r[1] == $past(apb_req.pwdata))
    else $error("write to second table word not stored");

  pending_set_a: assert property (@(posedge clk) disable iff (rst)
    tbl_wr && upstream_mode |=> pend_r)
    else $error("table write did not set pending status");

  load_clear_a: assert property (@(posedge clk) disable iff (rst)
    seq_load_start ##1 seq_copy_quiet and upstream_mode [*4] |=> !pend_r && ld_r == LD_IDLE)
    else $error("load did not finish in three copy cycles");

  downstream_a: assert property (@(posedge clk) disable iff (rst)
    !upstream_mode |=> !pend_r && ld_r == LD_IDLE ||
      $past(ld_r) == LD_COPY)
    else $error("pending or load active on a downstream port");

  scheme_gate_a: assert property (@(posedge clk) disable iff (rst)
    !table_use |=> $stable(phase_r) && !grant_valid_r)
    else $error("table steered arbitration under a non-table scheme");

  phase_range_a: assert property (@(posedge clk) disable iff (rst)
    phase_r <= 5'h17)
    else $error("phase pointer beyond last implemented phase");

endmodule : port_arbitration_phase_table

// ===== tb/tb_top.sv
/*
  Self-checking bench for the port arbitration phase table.
  Assumes the design answers APB in one access cycle and a 4 ns core clock.
*/
`timescale 1ns/1ps
`include "arb_table_params.svh"

// Compares a design value with the expected one and counts the result
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
  num_errors++; $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module tb_top
  import arb_table_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  apb_req_type req = '0;
  logic        upstream_mode = 1'b1;
  logic        phase_advance = 1'b0;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  slot_type    grant_port_r;
  logic        grant_valid_r;
  logic        table_used_r;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [31:0] wk [3];  // Expected working copy
  int          ptr = 23;
  logic [31:0] rd;
  logic        err;

  // Core clock
  always #2 clk = ~clk;

  port_arbitration_phase_table i_port_arbitration_phase_table (
    .clk           (clk),
    .rst           (rst),
    .apb_req       (req),
    .upstream_mode (upstream_mode),
    .phase_advance (phase_advance),
    .prdata_r      (prdata_r),
    .pready_r      (pready_r),
    .pslverr_r     (pslverr_r),
    .grant_port_r  (grant_port_r),
    .grant_valid_r (grant_valid_r),
    .table_used_r  (table_used_r)
  );

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // Cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end

  // One APB transfer, held until pready is sampled high; only the timeout ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready_r !== 1'b1);
    rd = prdata_r;
    err = pslverr_r;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // Expected grant after one advance: next valid slot, ascending with wrap
  task automatic adv(input logic used);
    int p;
    logic [3:0] c;
    logic ok;
    phase_advance <= 1'b1;
    @(posedge clk);
    phase_advance <= 1'b0;
    @(negedge clk);  // Grant has settled half a cycle after the advance edge
    ok = 1'b0;
    if (used) begin
      for (int i = 1; i <= 24 && !ok; i++) begin
        p = (ptr + i) % 24;
        c = wk[p / 8][4 * (p % 8) +: 4];
        if (c == 4'h0 || c == 4'h2 || c == 4'h4) begin
          ok = 1'b1;
          ptr = p;
        end
      end
    end
    `CHK("grant_valid", ok, grant_valid_r)
    if (ok) `CHK("grant_port", wk[ptr / 8][4 * (ptr % 8) +: 4], grant_port_r)
    @(posedge clk);
  endtask : adv

  // Reset values, unmapped offset, reset pattern walk
  task automatic t_reset();
    wk = '{`ARB_TBL0_RST, `ARB_TBL1_RST, `ARB_TBL2_RST};
    apb(1'b0, `ARB_TBL0_OFF, 32'h0);
    `CHK("word0 reset", 32'h42642642, rd)
    `CHK("word0 err", 1'b0, err)
    apb(1'b0, `ARB_TBL1_OFF, 32'h0);
    `CHK("word1 reset", 32'h26426426, rd)
    apb(1'b0, `ARB_TBL2_OFF, 32'h0);
    `CHK("word2 reset", 32'h64264264, rd)
    apb(1'b0, 12'h22c, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, `ARB_CTRL_OFF, 32'h0002_0000);
    repeat (2) @(posedge clk);
    `CHK("table used", 1'b1, table_used_r)
    for (int i = 0; i < 10; i++) adv(1'b1);
  endtask : t_reset

  // Table writes, pending status, load and walk over the new table
  task automatic t_load();
    logic [31:0] nw [3];
    nw = '{32'h2442_4224, 32'h4224_2442, 32'h2244_4422};
    for (int i = 0; i < 3; i++) apb(1'b1, `ARB_TBL0_OFF + 12'(4 * i), nw[i]);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, `ARB_TBL0_OFF + 12'(4 * i), 32'h0);
      `CHK("word readback", nw[i], rd)
    end
    adv(1'b1);
    apb(1'b0, `ARB_STAT_OFF, 32'h0);
    `CHK("pending set", 32'h0001_0000, rd)
    apb(1'b1, `ARB_CTRL_OFF, 32'h0003_0000);
    apb(1'b0, `ARB_CTRL_OFF, 32'h0);
    `CHK("load reads zero", 32'h0002_0000, rd)
    repeat (4) @(posedge clk);
    apb(1'b0, `ARB_STAT_OFF, 32'h0);
    `CHK("pending clear", 32'h0, rd)
    wk = nw;
    for (int i = 0; i < 30; i++) adv(1'b1);
  endtask : t_load

  // Downstream: pending stays zero and load is ignored
  task automatic t_down();
    upstream_mode <= 1'b0;
    apb(1'b1, `ARB_TBL0_OFF, 32'h4444_2222);
    apb(1'b0, `ARB_STAT_OFF, 32'h0);
    `CHK("pending down", 32'h0, rd)
    apb(1'b1, `ARB_CTRL_OFF, 32'h0003_0000);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 6; i++) adv(1'b1);
    upstream_mode <= 1'b1;
  endtask : t_down

  // Non-table scheme: advances grant nothing
  task automatic t_scheme();
    apb(1'b1, `ARB_CTRL_OFF, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("table unused", 1'b0, table_used_r)
    adv(1'b0);
    apb(1'b1, `ARB_CTRL_OFF, 32'h000e_0000);
    repeat (2) @(posedge clk);
    adv(1'b1);
  endtask : t_scheme

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_load();
    t_down();
    t_scheme();
    print_verdict();
  end

endmodule : tb_top
